// ### inc/serial_cmd_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the serial
  command interpreter.
  Assumes the includer treats every value as a plain sized constant.
*/
`ifndef SERIAL_CMD_CFG_SVH
`define SERIAL_CMD_CFG_SVH

// Clock and time base.
`define CLK_HZ 100000000
`define CLK_PERIOD_NS 10
`define TICK_NS 10000000
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
`define TICKS_PER_S 7'h64
`define GUARD_S 1
`define TIME_REPEAT_S 6'h3c

// Register byte addresses.
`define ADDR_CMD 8'h00
`define ADDR_ARG 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_CONN 8'h0c
`define ADDR_PINS 8'h10

// Status register bit positions.
`define ST_ERR 0
`define ST_CMD_MODE 1
`define ST_ASLEEP 2
`define ST_CONNECTED 3

// Status word fields.
`define CONN_FIXED 4'h8
`define PINS_FIXED 4'h8
`define TCP_CONNECTED 4'h1

// Reset values and the fixed direction bits.
`define RATE_RESET 4'h1
`define CHMASK_RESET 13'h1fff
`define BAUD_RESET 20'h028b0
`define DIR_RESET 10'h079
`define DIR_FIXED 10'h180

// Escape character and reply text positions.
`define ESC_CHAR 8'h24
`define RP_CMD_FIRST 5'h00
`define RP_CMD_LAST 5'h02
`define RP_EXIT_FIRST 5'h03
`define RP_EXIT_LAST 5'h06
`define RP_ERR_FIRST 5'h07
`define RP_ERR_LAST 5'h18

`endif

// ### inc/serial_cmd_pkg.sv
/*
  Types of the serial command interpreter: escape states and command codes.
  Assumes nothing beyond the constants header.
*/
package serial_cmd_pkg;

  // Escape sequence tracking, one-hot.
  typedef enum logic [4:0] {
    ESC_DATA  = 5'b00001,
    ESC_ONE   = 5'b00010,
    ESC_TWO   = 5'b00100,
    ESC_THREE = 5'b01000,
    ESC_CMD   = 5'b10000
  } esc_state_t;

  // Command codes written to the command register.
  typedef enum logic [7:0] {
    C_PROTO = 8'h01, C_AUTOCONN = 8'h02, C_SLEEP = 8'h03, C_WAKE = 8'h04,
    C_TRIGGER = 8'h05, C_MASK = 8'h06, C_OUT_ALL = 8'h07, C_OUT_MASK = 8'h08,
    C_FLOW = 8'h09, C_TX = 8'h0a, C_PARITY = 8'h0b, C_BAUD = 8'h0c,
    C_RAW = 8'h0d, C_TIME = 8'h0e, C_CHAN = 8'h0f, C_CHMASK = 8'h10,
    C_RATE = 8'h11, C_AUTH = 8'h12, C_IDLE = 8'h13, C_PRINT = 8'h14,
    C_IOFUNC = 8'h15, C_EXIT = 8'h16
  } cmd_code_t;

endpackage

// ### hw/serial_cmd_core.sv
/*
  Serial command interpreter: escape detection, command execution,
  power and connection timers, status words.
  Assumes a UART byte stream and network status on clk_sys, and pins
  and sensor inputs from outside that are synchronised here.
*/
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "serial_cmd_cfg.svh"

module serial_cmd_core #(
  parameter int TICK_CYC = `TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic fwd_valid,
  output logic [7:0] fwd_byte,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic net_traffic,
  input wire logic udp_tx_start,
  input wire logic [3:0] tcp_state,
  input wire logic assoc,
  input wire logic authed,
  input wire logic dns_contacted,
  input wire logic dns_resolved,
  input wire logic [3:0] sens_in,
  input wire logic [9:0] pin_in,
  output logic [9:0] gpio_out,
  output logic [9:0] gpio_oe_n,
  output logic tx_pulldown,
  output logic cmd_mode,
  output logic low_power,
  output logic connect_req,
  output logic disconnect_req,
  output logic scan_req,
  output logic time_req,
  output logic [1:0] proto,
  output logic flow_en,
  output logic [1:0] parity,
  output logic [19:0] baud_div,
  output logic [3:0] chan,
  output logic [12:0] chan_mask,
  output logic [3:0] rate,
  output logic [1:0] auth,
  output logic [1:0] time_mode,
  output logic [7:0] debug_message_select,
  output logic [2:0] iofunc
);
  import serial_cmd_pkg::*;

  // Reply text: acknowledge, exit and error strings back to back.
  function automatic logic [7:0] reply_rom(input logic [4:0] i);
    case (i)
      5'h00: reply_rom = 8'h43;
      5'h01: reply_rom = 8'h4d;
      5'h02: reply_rom = 8'h44;
      5'h03: reply_rom = 8'h45;
      5'h04: reply_rom = 8'h58;
      5'h05: reply_rom = 8'h49;
      5'h06: reply_rom = 8'h54;
      5'h07: reply_rom = 8'h45;
      5'h08: reply_rom = 8'h52;
      5'h09: reply_rom = 8'h52;
      5'h0a: reply_rom = 8'h4f;
      5'h0b: reply_rom = 8'h52;
      5'h0c: reply_rom = 8'h3a;
      5'h0d: reply_rom = 8'h20;
      5'h0e: reply_rom = 8'h55;
      5'h0f: reply_rom = 8'h6e;
      5'h10: reply_rom = 8'h6b;
      5'h11: reply_rom = 8'h6e;
      5'h12: reply_rom = 8'h6f;
      5'h13: reply_rom = 8'h77;
      5'h14: reply_rom = 8'h6e;
      5'h15: reply_rom = 8'h20;
      5'h16: reply_rom = 8'h43;
      5'h17: reply_rom = 8'h6d;
      5'h18: reply_rom = 8'h64;
      default: reply_rom = 8'h00;
    endcase
  endfunction

  // Divisor for each standard rate index, 0 = 1200 up to 10 = 921600.
  function automatic logic [19:0] std_div(input logic [3:0] i);
    case (i)
      4'h0: std_div = 20'(`CLK_HZ / 1200);
      4'h1: std_div = 20'(`CLK_HZ / 2400);
      4'h2: std_div = 20'(`CLK_HZ / 4800);
      4'h3: std_div = 20'(`CLK_HZ / 9600);
      4'h4: std_div = 20'(`CLK_HZ / 19200);
      4'h5: std_div = 20'(`CLK_HZ / 38400);
      4'h6: std_div = 20'(`CLK_HZ / 57600);
      4'h7: std_div = 20'(`CLK_HZ / 115200);
      4'h8: std_div = 20'(`CLK_HZ / 230400);
      4'h9: std_div = 20'(`CLK_HZ / 460800);
      default: std_div = 20'(`CLK_HZ / 921600);
    endcase
  endfunction

  logic [31:0] tick_cnt;
  logic tick, sec_tick;
  logic [6:0] sub_cnt, quiet_cnt;
  logic [3:0] sens_s1, sens_s2;
  logic [9:0] pin_s1, pin_s2;
  esc_state_t esc_st;
  logic [1:0] flush_n;
  logic pend_b;
  logic [7:0] pend_byte;
  logic [4:0] rp_idx, rp_end;
  logic [31:0] arg;
  logic err_flag;
  logic [15:0] sleep_cfg, sleep_cnt, wake_cfg, wake_cnt;
  logic [15:0] ac_cfg, ac_cnt, idle_cfg, idle_cnt;
  logic ac_armed, ac_fired, time_done;
  logic [5:0] time_sec;
  logic [2:0] trig;
  logic [9:0] dir_mask, out_lvl;
  logic tx_en;
  logic time_restart;

  // Time base: a 10 ms tick and a one second tick from it.
  // A seconds timer write restarts the base so that its first second is whole.
  // Other running timers may then see one second stretched.
  assign tick = (tick_cnt == 32'(TICK_CYC - 1));
  assign sec_tick = tick && (sub_cnt == `TICKS_PER_S - 7'h01);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      sub_cnt <= 7'h0;
    end else if (time_restart) begin
      tick_cnt <= 32'h0;
      sub_cnt <= 7'h0;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
      if (tick)
        sub_cnt <= sec_tick ? 7'h0 : sub_cnt + 7'h01;
    end
  end

  // Two-stage synchronisers for sensor and pin levels.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sens_s1 <= 4'hf;
      sens_s2 <= 4'hf;
      pin_s1 <= 10'h0;
      pin_s2 <= 10'h0;
    end else begin
      sens_s1 <= sens_in;
      sens_s2 <= sens_s1;
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // Register decode and command classification.
  wire cmd_wr = reg_wr && (reg_addr == `ADDR_CMD);
  wire [7:0] code = reg_wdata[7:0];
  wire is_dollar = (rx_byte == `ESC_CHAR);
  wire quiet = (quiet_cnt == `TICKS_PER_S);
  wire connected = (tcp_state == `TCP_CONNECTED);
  wire proto_tcp = (proto == 2'h1) || (proto == 2'h2);
  wire proto_udp = (proto == 2'h0);
  wire guard_done = (esc_st == ESC_THREE) && quiet;
  logic known;
  always_comb begin
    case (code)
      C_PROTO, C_AUTH: known = (arg[31:2] == 30'h0);
      C_TIME: known = (arg[31:0] < 32'h3);
      C_PARITY: known = (arg[31:0] < 32'h3);
      C_BAUD: known = (arg[31:0] < 32'hb);
      C_CHAN: known = (arg[31:0] < 32'he);
      C_RATE: known = (arg == 32'h1) || (arg == 32'h2)
        || (arg == 32'h4) || (arg == 32'h8);
      C_TRIGGER: known = (arg[31:0] < 32'h5);
      C_FLOW, C_TX: known = (arg[31:1] == 31'h0);
      C_AUTOCONN, C_SLEEP, C_WAKE, C_MASK, C_OUT_ALL, C_OUT_MASK,
      C_RAW, C_CHMASK, C_IDLE, C_PRINT, C_IOFUNC, C_EXIT: known = 1'b1;
      default: known = 1'b0;
    endcase
  end
  wire exec = cmd_wr && known;
  wire bad_cmd = cmd_wr && !known;
  wire do_exit = exec && (code == C_EXIT);
  // Any write of a seconds timer restarts the shared time base.
  assign time_restart = exec && ((code == C_SLEEP) || (code == C_WAKE)
    || (code == C_AUTOCONN) || (code == C_IDLE));

  // Escape sequence tracking and mode; data mode after reset.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      esc_st <= ESC_DATA;
      quiet_cnt <= 7'h0;
      flush_n <= 2'h0;
      pend_b <= 1'b0;
      pend_byte <= 8'h0;
    end else begin
      if (rx_valid)
        quiet_cnt <= 7'h0;
      else if (tick && !quiet)
        quiet_cnt <= quiet_cnt + 7'h01;
      if (guard_done)
        esc_st <= ESC_CMD;
      else if (do_exit)
        esc_st <= ESC_DATA;
      if (rx_valid && !low_power) begin
        case (esc_st)
          ESC_DATA: begin
            if (is_dollar && quiet) begin
              esc_st <= ESC_ONE;
            end else begin
              pend_b <= 1'b1;
              pend_byte <= rx_byte;
            end
          end
          ESC_ONE, ESC_TWO: begin
            if (is_dollar) begin
              esc_st <= (esc_st == ESC_ONE) ? ESC_TWO : ESC_THREE;
            end else begin
              esc_st <= ESC_DATA;
              flush_n <= (esc_st == ESC_ONE) ? 2'h1 : 2'h2;
              pend_b <= 1'b1;
              pend_byte <= rx_byte;
            end
          end
          ESC_THREE: begin
            esc_st <= ESC_DATA;
            flush_n <= 2'h3;
            pend_b <= 1'b1;
            pend_byte <= rx_byte;
          end
          ESC_CMD: ;
          default: esc_st <= ESC_DATA;
        endcase
      end else if (flush_n != 2'h0) begin
        flush_n <= flush_n - 2'h1;
      end else begin
        pend_b <= 1'b0;
      end
    end
  end

  // Forwarded data and command-mode bytes, one per cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid <= 1'b0;
      fwd_byte <= 8'h0;
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h0;
      cmd_mode <= 1'b0;
    end else begin
      fwd_valid <= (flush_n != 2'h0) || pend_b;
      fwd_byte <= (flush_n != 2'h0) ? `ESC_CHAR : pend_byte;
      cmd_valid <= rx_valid && !low_power && (esc_st == ESC_CMD);
      cmd_byte <= rx_byte;
      cmd_mode <= (esc_st == ESC_CMD);
    end
  end

  // Reply sender: acknowledge on entry, exit text, unknown-command error.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_byte <= 8'h0;
      rp_idx <= 5'h0;
      rp_end <= 5'h0;
    end else if (guard_done) begin
      tx_valid <= 1'b1;
      tx_byte <= reply_rom(`RP_CMD_FIRST);
      rp_idx <= `RP_CMD_FIRST;
      rp_end <= `RP_CMD_LAST;
    end else if (bad_cmd) begin
      tx_valid <= 1'b1;
      tx_byte <= reply_rom(`RP_ERR_FIRST);
      rp_idx <= `RP_ERR_FIRST;
      rp_end <= `RP_ERR_LAST;
    end else if (do_exit) begin
      tx_valid <= 1'b1;
      tx_byte <= reply_rom(`RP_EXIT_FIRST);
      rp_idx <= `RP_EXIT_FIRST;
      rp_end <= `RP_EXIT_LAST;
    end else if (tx_valid && tx_ready) begin
      if (rp_idx == rp_end) begin
        tx_valid <= 1'b0;
      end else begin
        rp_idx <= rp_idx + 5'h01;
        tx_byte <= reply_rom(rp_idx + 5'h01);
      end
    end
  end

  // Settings written by recognised commands only; the argument by any write to its address.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arg <= 32'h0;
      proto <= 2'h0;
      sleep_cfg <= 16'h0;
      wake_cfg <= 16'h0;
      ac_cfg <= 16'h0;
      idle_cfg <= 16'h0;
      trig <= 3'h0;
      dir_mask <= `DIR_RESET;
      out_lvl <= 10'h0;
      flow_en <= 1'b0;
      tx_en <= 1'b1;
      parity <= 2'h0;
      baud_div <= `BAUD_RESET;
      time_mode <= 2'h0;
      chan <= 4'h0;
      chan_mask <= `CHMASK_RESET;
      rate <= `RATE_RESET;
      auth <= 2'h0;
      debug_message_select <= 8'h0;
      iofunc <= 3'h0;
    end else begin
      if (reg_wr && (reg_addr == `ADDR_ARG))
        arg <= reg_wdata;
      if (exec) begin
        case (code)
          C_PROTO: proto <= arg[1:0];
          C_SLEEP: sleep_cfg <= arg[15:0];
          C_WAKE: wake_cfg <= arg[15:0];
          C_AUTOCONN: ac_cfg <= arg[15:0];
          C_IDLE: idle_cfg <= arg[15:0];
          C_TRIGGER: trig <= arg[2:0];
          C_MASK: dir_mask <= (arg[9:0] & ~`DIR_FIXED)
            | (dir_mask & `DIR_FIXED);
          C_OUT_ALL: out_lvl <= arg[9:0];
          C_OUT_MASK: out_lvl <= (out_lvl & ~arg[25:16])
            | (arg[9:0] & arg[25:16]);
          C_FLOW: flow_en <= arg[0];
          C_TX: tx_en <= arg[0];
          C_PARITY: parity <= arg[1:0];
          C_BAUD: baud_div <= std_div(arg[3:0]);
          C_RAW: baud_div <= arg[19:0];
          C_TIME: time_mode <= arg[1:0];
          C_CHAN: chan <= arg[3:0];
          C_CHMASK: chan_mask <= arg[12:0];
          C_RATE: rate <= arg[3:0];
          C_AUTH: auth <= arg[1:0];
          C_PRINT: debug_message_select <= arg[7:0];
          C_IOFUNC: iofunc <= arg[2:0];
          default: ;
        endcase
      end
    end
  end

  // Sleep, wake and sensor wake.
  wire sleep_paused = connected || (esc_st == ESC_CMD);
  wire sleep_step = sec_tick && !sleep_paused && !low_power && (sleep_cnt != 16'h0);
  wire sleep_hit = sleep_step && (sleep_cnt == 16'h1);
  wire ac_step_udp = proto_udp && ac_armed && tick && (ac_cnt != 16'h0);
  wire udp_sleep = ac_step_udp && (ac_cnt == 16'h1) && !low_power;
  wire wake_hit = low_power && sec_tick && (wake_cnt == 16'h1);
  wire sens_hit = low_power && (trig != 3'h0) && (trig < 3'h5)
    && !sens_s2[2'(trig - 3'h1)];
  wire wake_now = wake_hit || sens_hit;
  wire sleep_wr = exec && (code == C_SLEEP);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_power <= 1'b0;
      sleep_cnt <= 16'h0;
      wake_cnt <= 16'h0;
    end else begin
      if (sleep_hit || udp_sleep)
        low_power <= 1'b1;
      else if (wake_now)
        low_power <= 1'b0;
      if (sleep_wr)
        sleep_cnt <= arg[15:0];
      else if ((rx_valid && !low_power) || wake_now)
        sleep_cnt <= sleep_cfg;
      else if (sleep_step)
        sleep_cnt <= sleep_cnt - 16'h1;
      if (sleep_hit || udp_sleep)
        wake_cnt <= wake_cfg;
      else if (low_power && sec_tick && (wake_cnt != 16'h0))
        wake_cnt <= wake_cnt - 16'h1;
    end
  end

  // Auto-connect, UDP auto-sleep and idle disconnect.
  wire ac_wr = exec && (code == C_AUTOCONN);
  wire ac_step_tcp = (proto == 2'h1) && !ac_fired && !connected
    && sec_tick && (ac_cnt != 16'h0);
  wire idle_step = proto_tcp && connected && sec_tick && (idle_cnt != 16'h0);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ac_cnt <= 16'h0;
      ac_armed <= 1'b0;
      ac_fired <= 1'b0;
      idle_cnt <= 16'h0;
      connect_req <= 1'b0;
      disconnect_req <= 1'b0;
    end else begin
      connect_req <= ac_step_tcp && (ac_cnt == 16'h1);
      disconnect_req <= idle_step && (idle_cnt == 16'h1);
      if (ac_wr || wake_now) begin
        ac_cnt <= ac_wr ? arg[15:0] : ac_cfg;
        ac_armed <= 1'b0;
        ac_fired <= 1'b0;
      end else begin
        if (proto_udp && udp_tx_start)
          ac_armed <= 1'b1;
        if (ac_step_udp || ac_step_tcp)
          ac_cnt <= ac_cnt - 16'h1;
        if (ac_step_tcp && (ac_cnt == 16'h1))
          ac_fired <= 1'b1;
      end
      if (exec && (code == C_IDLE))
        idle_cnt <= arg[15:0];
      else if (rx_valid || net_traffic || !connected)
        idle_cnt <= idle_cfg;
      else if (idle_step)
        idle_cnt <= idle_cnt - 16'h1;
    end
  end

  // Time requests, scan requests and pin drive.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      time_req <= 1'b0;
      time_done <= 1'b0;
      time_sec <= 6'h0;
      scan_req <= 1'b0;
      gpio_out <= 10'h0;
      gpio_oe_n <= 10'h3ff;
      tx_pulldown <= 1'b0;
    end else begin
      time_req <= 1'b0;
      if (sec_tick) begin
        time_sec <= (time_sec == `TIME_REPEAT_S - 6'h01) ? 6'h0 : time_sec + 6'h01;
        if ((time_mode == 2'h1) && !time_done) begin
          time_req <= 1'b1;
          time_done <= 1'b1;
        end else if ((time_mode == 2'h2) && (time_sec == 6'h0)) begin
          time_req <= 1'b1;
        end
      end
      scan_req <= exec && (code == C_CHAN) && (arg[3:0] == 4'h0);
      gpio_out <= out_lvl;
      gpio_oe_n <= {~dir_mask[9:1], ~tx_en};
      tx_pulldown <= !tx_en;
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads give zero.
  wire [31:0] status_word = {28'h0, connected, low_power, cmd_mode, err_flag};
  wire [31:0] conn_word = {15'h0, `CONN_FIXED, chan, 1'b0, dns_resolved,
    dns_contacted, authed, assoc, tcp_state};
  wire [31:0] pins_word = {16'h0, `PINS_FIXED, 2'h0, pin_s2};
  wire st_clr = reg_wr && (reg_addr == `ADDR_STATUS) && reg_wdata[`ST_ERR];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
      err_flag <= 1'b0;
    end else begin
      if (bad_cmd)
        err_flag <= 1'b1;
      else if (st_clr)
        err_flag <= 1'b0;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_ARG: reg_rdata <= arg;
          `ADDR_STATUS: reg_rdata <= status_word;
          `ADDR_CONN: reg_rdata <= conn_word;
          `ADDR_PINS: reg_rdata <= pins_word;
          default: reg_rdata <= 32'h0;
        endcase
      end else begin
        reg_rdata <= 32'h0;
      end
    end
  end

endmodule
`default_nettype wire

// ### test/serial_cmd_core_props.sv
/*
  Port checks on the serial command interpreter.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_cmd_core_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic fwd_valid,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic [9:0] gpio_oe_n,
  input wire logic tx_pulldown,
  input wire logic cmd_mode,
  input wire logic low_power,
  input wire logic connect_req,
  input wire logic [3:0] chan
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // A register read of one address.
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  a_cmd_bytes: assert property (cmd_mode && rx_valid && !low_power |=> cmd_valid
    && cmd_byte == $past(rx_byte)) else $error("command byte not passed on");
  a_no_fwd_cmd: assert property (cmd_mode |-> !fwd_valid)
    else $error("data forwarded in command mode");
  a_cmd_reply: assert property ($rose(cmd_mode) |-> $past(tx_valid) && $past(tx_byte) == 8'h43)
    else $error("command entry reply missing");
  a_reply_holds: assert property (tx_valid && !tx_ready |=> tx_valid)
    else $error("reply byte dropped before taken");
  a_conn_fixed: assert property (s_rd(8'h0c) |=> reg_rdata[16:13] == 4'h8
    && reg_rdata[12:9] == $past(chan)) else $error("connection word wrong");
  a_pins_fixed: assert property (s_rd(8'h10) |=> reg_rdata[31:10] == 22'h20)
    else $error("pin word lead nibble wrong");
  a_fixed_inputs: assert property (gpio_oe_n[8:7] == 2'b11)
    else $error("fixed input pins driven");
  a_tx_pulldown: assert property (tx_pulldown && $past(tx_pulldown) |-> gpio_oe_n[0])
    else $error("disabled transmit pin still driven");
  a_conn_pulse: assert property (connect_req |=> !connect_req)
    else $error("connect request longer than one cycle");
endmodule
bind serial_cmd_core serial_cmd_core_props u_props (.clk_sys, .rst_n, .reg_addr, .reg_rd,
  .reg_rdata, .rx_valid, .rx_byte, .fwd_valid, .cmd_valid, .cmd_byte, .tx_valid, .tx_byte,
  .tx_ready, .gpio_oe_n, .tx_pulldown, .cmd_mode, .low_power, .connect_req, .chan);
`default_nettype wire

// ### test/uart_host_model.sv
/*
  Host on the serial link: sends bytes and takes reply bytes.
  Assumes the bench calls send and reads got.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_host_model (
  input wire logic clk_sys,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output logic [31:0] got
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
    got = 32'h0;
  end
  // Takes reply bytes, stalling at random so replies must wait.
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) got <= {got[23:0], tx_byte};
    tx_ready <= 1'($urandom % 2);
  end
  // Sends a byte, then keeps a byte time of quiet with junk on the idle line.
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
    repeat (5) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ### test/tb_serial_cmd_core.sv
/*
  Self-checking bench for the serial command interpreter.
  Assumes the host model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_cmd_cfg.svh"
module tb_serial_cmd_core;
  import serial_cmd_pkg::*;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, udp_tx_start = 0;
  logic net_traffic = 0, assoc = 0, authed = 0, dns_contacted = 0, dns_resolved = 0;
  logic [7:0] reg_addr = 0, rx_byte, fwd_byte, tx_byte, b;
  logic [31:0] reg_wdata = 0, reg_rdata, got;
  logic [3:0] tcp_state = 0, sens_in = 4'hf, chan, rate;
  logic [9:0] pin_in = 0, gpio_out, gpio_oe_n, m;
  logic rx_valid, fwd_valid, tx_valid, tx_ready, tx_pulldown, cmd_mode, low_power;
  logic connect_req, disconnect_req, flow_en;
  logic [1:0] proto, parity, auth, time_mode;
  logic [19:0] baud_div;
  logic [12:0] chan_mask;
  int errors = 0, num_checks = 0, cyc = 0;
  logic [31:0] exp_q[$];
  uart_host_model host (.clk_sys, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready, .got);
  serial_cmd_core #(.TICK_CYC(4)) dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .rx_valid, .rx_byte, .fwd_valid, .fwd_byte, .cmd_valid(), .cmd_byte(),
    .tx_valid, .tx_byte, .tx_ready, .net_traffic, .udp_tx_start, .tcp_state, .assoc, .authed,
    .dns_contacted, .dns_resolved, .sens_in, .pin_in, .gpio_out, .gpio_oe_n, .tx_pulldown,
    .cmd_mode, .low_power, .connect_req, .disconnect_req, .scan_req(), .time_req(), .proto,
    .flow_en, .parity, .baud_div, .chan, .chan_mask, .rate, .auth, .time_mode,
    .debug_message_select(), .iofunc());
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Writes the argument, then the command code, back to back.
  task automatic setc(input logic [7:0] c, input logic [31:0] a);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= `ADDR_ARG;
    reg_wdata <= a;
    @(posedge clk_sys);
    reg_addr <= `ADDR_CMD;
    reg_wdata <= {24'h0, c};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // Reads one word and notes what it should hold.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // Counts cycles until an event shows and checks the count lies in range.
  task automatic wt(input int k, input int lo, input int hi, input string n);
    int c = 0;
    while (c <= hi && (k == 0 ? connect_req : k == 1 ? disconnect_req :
      k == 2 ? low_power : !low_power) !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    chk(n, c >= lo && c <= hi, 1);
  endtask
  // Compares read data and forwarded bytes with the oldest notes.
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d) chk("reg_rdata", reg_rdata, exp_q.size() ? exp_q.pop_front() : 'x);
    if (fwd_valid === 1'b1) chk("fwd_byte", fwd_byte, exp_q.size() ? exp_q.pop_front() : 'x);
  end
  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    void'($urandom(15));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("rate", rate, 1);
    chk("chan_mask", chan_mask, 13'h1fff);
    chk("baud_div", baud_div, 20'h028b0);
    chk("cmd_mode", cmd_mode, 0);
    for (int i = 0; i < 6; i++) begin
      b = (i == 2) ? `ESC_CHAR : 8'h41 + 8'($urandom % 26);
      exp_q.push_back(b);
      host.send(b);
    end
    repeat (420) @(posedge clk_sys);
    exp_q.push_back(`ESC_CHAR);
    exp_q.push_back(8'h5a);
    host.send(`ESC_CHAR);
    host.send(8'h5a);
    repeat (420) @(posedge clk_sys);
    repeat (3) host.send(`ESC_CHAR);
    repeat (420) @(posedge clk_sys);
    #1;
    chk("cmd_mode", cmd_mode, 1);
    repeat (40) @(posedge clk_sys);
    chk("reply", got[23:0], "CMD");
    host.send(8'h61);
    for (int i = 0; i < 4; i++) begin
      setc(C_PROTO, i);
      chk("proto", proto, i);
      setc(C_AUTH, i);
      chk("auth", auth, i);
      setc(C_RATE, 1 << i);
      chk("rate", rate, 1 << i);
      setc(C_PARITY, i % 3);
      chk("parity", parity, i % 3);
      setc(C_TIME, i % 3);
      chk("time_mode", time_mode, i % 3);
      setc(C_FLOW, i % 2);
      chk("flow_en", flow_en, i % 2);
    end
    setc(C_BAUD, 3);
    chk("baud_div", baud_div, 20'h028b0);
    setc(C_RAW, 760);
    chk("baud_div", baud_div, 760);
    setc(C_CHMASK, 32'h0aa5);
    chk("chan_mask", chan_mask, 13'h0aa5);
    setc(C_CHAN, 0);
    chk("chan", chan, 0);
    setc(C_CHAN, 7);
    setc(C_CHAN, 14);
    chk("chan", chan, 7);
    setc(8'h7f, 0);
    chk("proto", proto, 3);
    rd(`ADDR_STATUS, 32'h3);
    setc(C_MASK, 32'h3ff);
    chk("gpio_oe_n", gpio_oe_n[9:1], 9'h0c0);
    m = 10'($urandom);
    setc(C_OUT_ALL, m);
    chk("gpio_out", gpio_out & 10'h27e, m & 10'h27e);
    setc(C_OUT_MASK, {6'h0, 10'h00f, 6'h0, ~m});
    chk("gpio_out", gpio_out & 10'h27e, (m ^ 10'h00f) & 10'h27e);
    setc(C_TX, 0);
    chk("tx_pulldown", tx_pulldown, 1);
    chk("gpio_oe_n", gpio_oe_n[0], 1);
    tcp_state <= 4'h4;
    assoc <= 1'b1;
    authed <= 1'b1;
    dns_contacted <= 1'b1;
    pin_in <= m;
    repeat (4) @(posedge clk_sys);
    rd(`ADDR_CONN, {15'h0, 4'h8, 4'h7, 5'h07, 4'h4});
    rd(`ADDR_PINS, {16'h0, 4'h8, 2'b0, m});
    tcp_state <= 4'h0;
    setc(C_PROTO, 1);
    setc(C_AUTOCONN, 1);
    wt(0, 380, 420, "autoconn");
    tcp_state <= 4'h1;
    setc(C_IDLE, 1);
    wt(1, 380, 420, "idle");
    tcp_state <= 4'h0;
    setc(C_TRIGGER, 2);
    setc(C_EXIT, 0);
    chk("cmd_mode", cmd_mode, 0);
    setc(C_SLEEP, 1);
    wt(2, 380, 420, "sleep");
    chk("reply", got, "EXIT");
    sens_in <= 4'hd;
    wt(3, 0, 8, "sensor_wake");
    sens_in <= 4'hf;
    setc(C_SLEEP, 0);
    setc(C_WAKE, 1);
    setc(C_PROTO, 0);
    setc(C_AUTOCONN, 3);
    @(posedge clk_sys);
    udp_tx_start <= 1'b1;
    @(posedge clk_sys);
    udp_tx_start <= 1'b0;
    wt(2, 6, 20, "autosleep");
    wt(3, 380, 420, "wake");
    summarize();
  end
endmodule
`default_nettype wire
